// >>> csa_arbiter.sv
// csa_arbiter: command source arbiter, one evaluation per clock edge
// assumes command inputs come from logic on clock; hand request and run
// feedback are pins and are synchronised; each clock edge is one scan
`timescale 1ns/1ps
`default_nettype none

// Operation
// - hand request held high makes hand the owner
// - maintenance taken on take command, dropped on give command
// - maintenance take seen flag high only for the scan it arrived
// - override beats a lock only when override_beats_lock is set
// - override request high makes override the owner
// - edge mode: external take and give act once, then get cleared
// - level mode: external take held keeps ownership, give ignored
// - external flag high while external owns the device
// - operator take moves to operator, operator give back to program
// - operator lock locks into operator, unlock removes it
// - lock stops operator and program taking, and override unless allowed
// - selection flag is one for program, zero for operator
// - operator and program flags each high only when that source owns
// - program take moves to program, program give back to operator
// - edge program mode: take and give one-shot, then cleared
// - level program mode: take held keeps program, give ignored
// - program lock locks into program, program unlock removes it
// - edge lock mode: lock acquires and locks, unlock unlocks, both cleared
// - level lock mode: lock held keeps locked, drop unlocks, unlock ignored
// - while in hand the run feedback is tracked for bumpless transfer
// - simultaneous requests resolve by priority, lower ones retained
// - first scan selects program or operator from the power-up setting
module csa_arbiter
    import csa_pkg::*;
(
    input  wire logic     clock,
    input  wire logic     reset,
    input  wire logic     hand_req,
    input  wire logic     run_fdbk,
    input  wire logic     ovrd_req,
    input  wire logic     maint_take_cmd,
    input  wire logic     maint_give_cmd,
    input  wire logic     ext_take_cmd,
    input  wire logic     ext_give_cmd,
    input  wire logic     oper_take_cmd,
    input  wire logic     oper_give_cmd,
    input  wire logic     oper_lock_cmd,
    input  wire logic     oper_unlock_cmd,
    input  wire logic     prog_take_cmd,
    input  wire logic     prog_give_cmd,
    input  wire logic     prog_lock_cmd,
    input  wire logic     prog_unlock_cmd,
    input  wire logic     override_beats_lock,
    input  wire logic     ext_beats_lock,
    input  wire logic     ext_level_mode,
    input  wire logic     prog_level_mode,
    input  wire logic     prog_lock_level_mode,
    input  wire logic     powerup_prog_select,
    output var  csa_own_t owner_flags,
    output var  logic     maint_take_seen_flag,
    output var  logic     prog_oper_locked_flag,
    output var  logic     prog_selected_flag,
    output var  logic     run_tracked_flag,
    output var  csa_cmd_t cmd_clear
);

    // synchronised pins and command edges
    csa_pin_t pin_raw, pin_sync;
    csa_cmd_t cmd_now, cmd_rise, cmd_fall;

    // retained request state
    logic     first_reg, first_next;
    logic     maint_reg, maint_next;
    logic     ext_reg, ext_next;
    logic     sel_reg, sel_next;
    logic     lock_reg, lock_next;
    logic     seen_reg, seen_next;
    logic     track_reg, track_next;
    csa_src_t own_reg, own_next;
    csa_cmd_t clr_reg, clr_next;

    // arbitration helpers
    logic     ovrd_ok;
    logic     ext_ok;
    logic     ext_want;

    // gather pins into one group for the synchroniser
    assign pin_raw.hand_req = hand_req;
    assign pin_raw.run_fdbk = run_fdbk;

    csa_sync #(
        .WIDTH     (CSA_PIN_W)
    ) u_sync (
        .clock     (clock),
        .reset     (reset),
        .pin_in    (pin_raw),
        .level_out (pin_sync)
    );

    // gather commands for edge detection
    always_comb begin
        cmd_now.maint_take  = maint_take_cmd;
        cmd_now.maint_give  = maint_give_cmd;
        cmd_now.ext_take    = ext_take_cmd;
        cmd_now.ext_give    = ext_give_cmd;
        cmd_now.oper_take   = oper_take_cmd;
        cmd_now.oper_give   = oper_give_cmd;
        cmd_now.oper_lock   = oper_lock_cmd;
        cmd_now.oper_unlock = oper_unlock_cmd;
        cmd_now.prog_take   = prog_take_cmd;
        cmd_now.prog_give   = prog_give_cmd;
        cmd_now.prog_lock   = prog_lock_cmd;
        cmd_now.prog_unlock = prog_unlock_cmd;
    end

    csa_edge #(
        .WIDTH    (CSA_CMD_W)
    ) u_edge (
        .clock    (clock),
        .reset    (reset),
        .cmd_in   (cmd_now),
        .rise_out (cmd_rise),
        .fall_out (cmd_fall)
    );

    // maintenance request, retained under higher sources
    always_comb begin
        maint_next = maint_reg;
        seen_next  = cmd_rise.maint_take;
        if (cmd_rise.maint_take) begin
            maint_next = 1'b1;
        end
        if (cmd_rise.maint_give) begin
            maint_next = 1'b0; // release wins a same-scan tie
        end
    end

    // external request in edge or level style
    always_comb begin
        ext_next = ext_reg;
        if (ext_level_mode) begin
            ext_next = ext_take_cmd;
        end else begin
            if (cmd_rise.ext_take) begin
                ext_next = 1'b1;
            end
            if (cmd_rise.ext_give) begin
                ext_next = 1'b0;
            end
        end
    end

    // program/operator selection and lock
    always_comb begin
        sel_next  = sel_reg;
        lock_next = lock_reg;
        if (first_reg) begin
            sel_next  = powerup_prog_select;
            lock_next = 1'b0;
        end else begin
            if (!lock_reg && cmd_rise.oper_take) begin
                sel_next = 1'b0;
            end
            if (!lock_reg && cmd_rise.oper_give) begin
                sel_next = 1'b1;
            end
            if (prog_level_mode) begin
                if (!lock_reg && prog_take_cmd) begin
                    sel_next = 1'b1;
                end
                if (!lock_reg && cmd_fall.prog_take) begin
                    sel_next = 1'b0;
                end
            end else begin
                if (!lock_reg && cmd_rise.prog_take) begin
                    sel_next = 1'b1;
                end
                if (!lock_reg && cmd_rise.prog_give) begin
                    sel_next = 1'b0;
                end
            end
            if (cmd_rise.oper_lock && (!lock_reg || !sel_reg)) begin
                sel_next  = 1'b0;
                lock_next = 1'b1;
            end
            if (cmd_rise.oper_unlock && lock_reg && !sel_reg) begin
                lock_next = 1'b0;
            end
            if (prog_lock_level_mode) begin
                if (prog_lock_cmd && (!lock_reg || sel_reg)) begin
                    sel_next  = 1'b1;
                    lock_next = 1'b1;
                end
                if (cmd_fall.prog_lock && lock_reg && sel_reg) begin
                    lock_next = 1'b0;
                end
            end else begin
                if (cmd_rise.prog_lock && (!lock_reg || sel_reg)) begin
                    sel_next  = 1'b1;
                    lock_next = 1'b1;
                end
                if (cmd_rise.prog_unlock && lock_reg && sel_reg) begin
                    lock_next = 1'b0;
                end
            end
        end
    end

    // clear strobes for commands taken as one-shots
    always_comb begin
        clr_next             = CSA_CMD_RST;
        clr_next.maint_take  = cmd_rise.maint_take;
        clr_next.maint_give  = cmd_rise.maint_give;
        clr_next.oper_take   = cmd_rise.oper_take;
        clr_next.oper_give   = cmd_rise.oper_give;
        clr_next.oper_lock   = cmd_rise.oper_lock;
        clr_next.oper_unlock = cmd_rise.oper_unlock;
        clr_next.ext_take    = cmd_rise.ext_take & ~ext_level_mode;
        clr_next.ext_give    = cmd_rise.ext_give & ~ext_level_mode;
        clr_next.prog_take   = cmd_rise.prog_take & ~prog_level_mode;
        clr_next.prog_give   = cmd_rise.prog_give & ~prog_level_mode;
        clr_next.prog_lock   = cmd_rise.prog_lock & ~prog_lock_level_mode;
        clr_next.prog_unlock = cmd_rise.prog_unlock & ~prog_lock_level_mode;
    end

    // owner arbitration on the freshly updated requests
    always_comb begin
        ovrd_ok  = ovrd_req && (!lock_next || override_beats_lock);
        ext_want = ext_next;
        ext_ok   = ext_want && (!lock_next || ext_beats_lock);
        if (pin_sync.hand_req) begin
            own_next = CSA_SRC_HAND;
        end else if (maint_next) begin
            own_next = CSA_SRC_MAINT;
        end else if (ovrd_ok) begin
            own_next = CSA_SRC_OVRD;
        end else if (ext_ok) begin
            own_next = CSA_SRC_EXT;
        end else if (sel_next) begin
            own_next = CSA_SRC_PROG;
        end else begin
            own_next = CSA_SRC_OPER;
        end
    end

    // run state tracking while hand owns
    always_comb begin
        track_next = track_reg;
        if (pin_sync.hand_req) begin
            track_next = pin_sync.run_fdbk;
        end
        first_next = 1'b0;
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            first_reg <= CSA_FIRST_RST;
            maint_reg <= CSA_BIT_RST;
            ext_reg   <= CSA_BIT_RST;
            sel_reg   <= CSA_BIT_RST;
            lock_reg  <= CSA_BIT_RST;
            seen_reg  <= CSA_BIT_RST;
            track_reg <= CSA_BIT_RST;
            own_reg   <= CSA_SRC_OPER;
            clr_reg   <= CSA_CMD_RST;
        end else begin
            first_reg <= first_next;
            maint_reg <= maint_next;
            ext_reg   <= ext_next;
            sel_reg   <= sel_next;
            lock_reg  <= lock_next;
            seen_reg  <= seen_next;
            track_reg <= track_next;
            own_reg   <= own_next;
            clr_reg   <= clr_next;
        end
    end

    assign owner_flags           = csa_own_t'(own_reg);
    assign maint_take_seen_flag  = seen_reg;
    assign prog_oper_locked_flag = lock_reg;
    assign prog_selected_flag    = sel_reg;
    assign run_tracked_flag      = track_reg;
    assign cmd_clear             = clr_reg;

endmodule
`default_nettype wire

// >>> csa_arbiter_chk.sv
// csa_arbiter_chk: port-level assertions for the command source arbiter
// assumes it is bound to csa_arbiter; commands are same-clock, hand is a pin
`timescale 1ns/1ps
`default_nettype none
module csa_arbiter_chk
    import csa_pkg::*;
(
    input wire logic     clock,
    input wire logic     reset,
    input wire logic     hand_req,
    input wire logic     ovrd_req,
    input wire logic     maint_take_cmd,
    input wire logic     ext_take_cmd,
    input wire logic     ext_level_mode,
    input wire logic     override_beats_lock,
    input wire csa_own_t owner_flags,
    input wire logic     maint_take_seen_flag,
    input wire logic     prog_oper_locked_flag,
    input wire logic     prog_selected_flag,
    input wire csa_cmd_t cmd_clear
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    // hand pin quiet long enough to have left the sync chain
    sequence s_no_hand; !hand_req [*8]; endsequence
    sequence s_maint_rise; maint_take_cmd && !$past(maint_take_cmd); endsequence
    sequence s_ext_rise; ext_take_cmd && !$past(ext_take_cmd) && !ext_level_mode; endsequence
    // ownership and selection
    chk_owner_one_hot: assert property ($onehot(owner_flags))
        else $error("owner flags not one-hot");
    chk_sel_follows: assert property ((owner_flags.prog || owner_flags.oper)
        |-> prog_selected_flag == owner_flags.prog)
        else $error("selection flag disagrees with owner");
    chk_hand_wins: assert property (hand_req [*8] |-> owner_flags.hand)
        else $error("held hand request not owner");
    // maintenance take and its one-scan flag
    chk_seen_pulse: assert property (maint_take_seen_flag |=> !maint_take_seen_flag)
        else $error("maintenance seen flag longer than one scan");
    chk_seen_cause: assert property (maint_take_seen_flag |-> $past(maint_take_cmd) && !$past(maint_take_cmd, 2))
        else $error("maintenance seen flag without a take edge");
    chk_maint_take: assert property (s_no_hand ##0 s_maint_rise
        |=> owner_flags.maint && cmd_clear.maint_take)
        else $error("maintenance take not granted");
    // override against the lock, and external take edge while unlocked
    chk_lock_blocks: assert property (prog_oper_locked_flag && !override_beats_lock && ovrd_req
        && (owner_flags.oper || owner_flags.prog) ##1 prog_oper_locked_flag |-> !owner_flags.ovrd)
        else $error("override took a locked source");
    chk_ovrd_takes: assert property (s_no_hand ##0 (ovrd_req && override_beats_lock && !maint_take_cmd
        && !owner_flags.maint) |=> owner_flags.ovrd)
        else $error("override request not granted");
    chk_ext_edge: assert property (s_no_hand ##0 s_ext_rise ##0 (!prog_oper_locked_flag && !ovrd_req
        && !maint_take_cmd && (owner_flags.oper || owner_flags.prog)) |=> owner_flags.ext && cmd_clear.ext_take)
        else $error("external take edge not granted");
    // level external commands belong to the source and are never cleared
    chk_level_no_clear: assert property (ext_level_mode |=> !cmd_clear.ext_take && !cmd_clear.ext_give)
        else $error("external command cleared in level mode");
endmodule
bind csa_arbiter csa_arbiter_chk csa_arbiter_chk_i (.clock(clock), .reset(reset), .hand_req(hand_req),
    .ovrd_req(ovrd_req), .maint_take_cmd(maint_take_cmd), .ext_take_cmd(ext_take_cmd),
    .ext_level_mode(ext_level_mode), .override_beats_lock(override_beats_lock), .owner_flags(owner_flags),
    .maint_take_seen_flag(maint_take_seen_flag), .prog_oper_locked_flag(prog_oper_locked_flag),
    .prog_selected_flag(prog_selected_flag), .cmd_clear(cmd_clear));
`default_nettype wire

// >>> csa_arbiter_tb.sv
// csa_arbiter_tb: self-checking bench for the command source arbiter
// assumes csa_src_model drives the commands; pins and config change at falling edge
`timescale 1ns/1ps
`default_nettype none
module csa_arbiter_tb
    import csa_pkg::*;
;
    typedef struct packed {
        logic [5:0] own;
        logic       sel;
        logic       lock;
        logic       seen;
        logic       run;
    } csa_exp_t;
    localparam csa_cmd_t cmd_maint_take  = 12'h800;
    localparam csa_cmd_t cmd_maint_give  = 12'h400;
    localparam csa_cmd_t cmd_ext_take    = 12'h200;
    localparam csa_cmd_t cmd_ext_give    = 12'h100;
    localparam csa_cmd_t cmd_oper_take   = 12'h080;
    localparam csa_cmd_t cmd_oper_give   = 12'h040;
    localparam csa_cmd_t cmd_oper_lock   = 12'h020;
    localparam csa_cmd_t cmd_oper_unlock = 12'h010;
    localparam csa_cmd_t cmd_prog_take   = 12'h008;
    localparam csa_cmd_t cmd_prog_give   = 12'h004;
    localparam csa_cmd_t cmd_prog_lock   = 12'h002;
    localparam csa_cmd_t cmd_prog_unlock = 12'h001;
    logic     clock = 1'b0;
    logic     reset = 1'b1;
    logic     hand_req = 1'b0;
    logic     run_fdbk = 1'b0;
    logic     ovrd_req = 1'b0;
    logic     override_beats_lock = 1'b0;
    logic     ext_beats_lock = 1'b0;
    logic     ext_level_mode = 1'b0;
    logic     prog_level_mode = 1'b0;
    logic     prog_lock_level_mode = 1'b0;
    logic     powerup_prog_select = 1'b0;
    csa_cmd_t req = 12'h000;
    csa_cmd_t hold = 12'h000;
    csa_cmd_t cmd;
    csa_cmd_t cmd_clear;
    csa_own_t owner_flags;
    logic     maint_take_seen_flag;
    logic     prog_oper_locked_flag;
    logic     prog_selected_flag;
    logic     run_tracked_flag;
    csa_exp_t exp_q[$];
    event     sample_ev;
    logic     exp_run = 1'b0;
    logic     rf;
    int       seed = 32'hD7F6;
    int       failures = 0;
    int       n_checks = 0;
    csa_src_model csa_src_model_i (.clock(clock), .reset(reset), .req(req), .hold(hold),
        .cmd_clear(cmd_clear), .cmd(cmd));
    csa_arbiter csa_arbiter_i (.clock(clock), .reset(reset), .hand_req(hand_req), .run_fdbk(run_fdbk),
        .ovrd_req(ovrd_req), .maint_take_cmd(cmd.maint_take), .maint_give_cmd(cmd.maint_give),
        .ext_take_cmd(cmd.ext_take), .ext_give_cmd(cmd.ext_give), .oper_take_cmd(cmd.oper_take),
        .oper_give_cmd(cmd.oper_give), .oper_lock_cmd(cmd.oper_lock), .oper_unlock_cmd(cmd.oper_unlock),
        .prog_take_cmd(cmd.prog_take), .prog_give_cmd(cmd.prog_give), .prog_lock_cmd(cmd.prog_lock),
        .prog_unlock_cmd(cmd.prog_unlock), .override_beats_lock(override_beats_lock),
        .ext_beats_lock(ext_beats_lock),
        .ext_level_mode(ext_level_mode), .prog_level_mode(prog_level_mode),
        .prog_lock_level_mode(prog_lock_level_mode), .powerup_prog_select(powerup_prog_select),
        .owner_flags(owner_flags), .maint_take_seen_flag(maint_take_seen_flag),
        .prog_oper_locked_flag(prog_oper_locked_flag), .prog_selected_flag(prog_selected_flag),
        .run_tracked_flag(run_tracked_flag), .cmd_clear(cmd_clear));
    // 25 MHz scan clock
    always #20 clock = ~clock;
    task automatic end_of_test();
        if (failures == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic cmp_state(input csa_exp_t e);
        csa_exp_t s;
        s = '{owner_flags, prog_selected_flag, prog_oper_locked_flag, maint_take_seen_flag, run_tracked_flag};
        n_checks++;
        if (s !== e) begin
            failures++;
            $display("MISMATCH state expected %h seen %h", e, s);
        end
    endtask
    // note an expectation, then let the monitor compare it
    task automatic expect_state(input logic [5:0] own, input logic sel, input logic lock, input logic seen);
        exp_q.push_back('{own, sel, lock, seen, exp_run});
        -> sample_ev;
    endtask
    // one-scan request through the sources, result seen a scan later
    task automatic pulse(input csa_cmd_t c);
        req <= c;
        @(negedge clock);
        req <= CSA_CMD_RST;
        @(negedge clock);
    endtask
    // bounded wait for the synchronised hand flag
    task automatic wait_hand(input logic v);
        int i;
        for (i = 0; i < 12 && owner_flags.hand !== v; i++) begin
            @(negedge clock);
        end
        if (owner_flags.hand !== v) begin
            failures++;
            end_of_test();
        end
    endtask
    // monitor takes the oldest note for each result
    always @(sample_ev) begin
        cmp_state(exp_q.pop_front());
    end
    // watchdog against a hang
    initial begin
        repeat (4000) @(posedge clock);
        failures++;
        end_of_test();
    end
    initial begin
        repeat (3) @(negedge clock);
        reset <= 1'b0;
        repeat (2) @(negedge clock);
        expect_state(CSA_SRC_OPER, 1'b0, 1'b0, 1'b0);
        pulse(cmd_prog_take);
        expect_state(CSA_SRC_PROG, 1'b1, 1'b0, 1'b0);
        pulse(cmd_prog_give);
        expect_state(CSA_SRC_OPER, 1'b0, 1'b0, 1'b0);
        pulse(cmd_oper_give);
        expect_state(CSA_SRC_PROG, 1'b1, 1'b0, 1'b0);
        pulse(cmd_oper_take);
        expect_state(CSA_SRC_OPER, 1'b0, 1'b0, 1'b0);
        pulse(cmd_oper_lock);
        expect_state(CSA_SRC_OPER, 1'b0, 1'b1, 1'b0);
        pulse(cmd_prog_take);
        expect_state(CSA_SRC_OPER, 1'b0, 1'b1, 1'b0);
        ovrd_req <= 1'b1;
        @(negedge clock);
        expect_state(CSA_SRC_OPER, 1'b0, 1'b1, 1'b0);
        override_beats_lock <= 1'b1;
        @(negedge clock);
        expect_state(CSA_SRC_OVRD, 1'b0, 1'b1, 1'b0);
        ovrd_req <= 1'b0;
        @(negedge clock);
        expect_state(CSA_SRC_OPER, 1'b0, 1'b1, 1'b0);
        pulse(cmd_oper_unlock);
        expect_state(CSA_SRC_OPER, 1'b0, 1'b0, 1'b0);
        pulse(cmd_prog_lock);
        expect_state(CSA_SRC_PROG, 1'b1, 1'b1, 1'b0);
        pulse(cmd_oper_take);
        expect_state(CSA_SRC_PROG, 1'b1, 1'b1, 1'b0);
        pulse(cmd_prog_unlock);
        expect_state(CSA_SRC_PROG, 1'b1, 1'b0, 1'b0);
        pulse(cmd_ext_take);
        expect_state(CSA_SRC_EXT, 1'b1, 1'b0, 1'b0);
        pulse(cmd_ext_give);
        expect_state(CSA_SRC_PROG, 1'b1, 1'b0, 1'b0);
        ext_level_mode <= 1'b1;
        hold.ext_take <= 1'b1;
        @(negedge clock);
        expect_state(CSA_SRC_EXT, 1'b1, 1'b0, 1'b0);
        pulse(cmd_ext_give);
        expect_state(CSA_SRC_EXT, 1'b1, 1'b0, 1'b0);
        hold.ext_take <= 1'b0;
        @(negedge clock);
        expect_state(CSA_SRC_PROG, 1'b1, 1'b0, 1'b0);
        ovrd_req <= 1'b1;
        @(negedge clock);
        expect_state(CSA_SRC_OVRD, 1'b1, 1'b0, 1'b0);
        pulse(cmd_maint_take);
        expect_state(CSA_SRC_MAINT, 1'b1, 1'b0, 1'b1);
        @(negedge clock);
        expect_state(CSA_SRC_MAINT, 1'b1, 1'b0, 1'b0);
        pulse(cmd_maint_give);
        expect_state(CSA_SRC_OVRD, 1'b1, 1'b0, 1'b0);
        ovrd_req <= 1'b0;
        hand_req <= 1'b1;
        wait_hand(1'b1);
        // random run feedback tracked while in hand
        for (int i = 0; i < 3; i++) begin
            rf = 1'($random(seed));
            run_fdbk <= rf;
            repeat (6) @(negedge clock);
            exp_run = rf;
            expect_state(CSA_SRC_HAND, 1'b1, 1'b0, 1'b0);
        end
        pulse(cmd_prog_give);
        expect_state(CSA_SRC_HAND, 1'b0, 1'b0, 1'b0);
        hand_req <= 1'b0;
        wait_hand(1'b0);
        expect_state(CSA_SRC_OPER, 1'b0, 1'b0, 1'b0);
        prog_lock_level_mode <= 1'b1;
        hold.prog_lock <= 1'b1;
        @(negedge clock);
        expect_state(CSA_SRC_PROG, 1'b1, 1'b1, 1'b0);
        pulse(cmd_prog_unlock);
        expect_state(CSA_SRC_PROG, 1'b1, 1'b1, 1'b0);
        hold.prog_lock <= 1'b0;
        @(negedge clock);
        expect_state(CSA_SRC_PROG, 1'b1, 1'b0, 1'b0);
        pulse(cmd_prog_give);
        expect_state(CSA_SRC_OPER, 1'b0, 1'b0, 1'b0);
        prog_level_mode <= 1'b1;
        hold.prog_take <= 1'b1;
        @(negedge clock);
        expect_state(CSA_SRC_PROG, 1'b1, 1'b0, 1'b0);
        pulse(cmd_prog_give);
        expect_state(CSA_SRC_PROG, 1'b1, 1'b0, 1'b0);
        hold.prog_take <= 1'b0;
        @(negedge clock);
        expect_state(CSA_SRC_OPER, 1'b0, 1'b0, 1'b0);
        // held external take against an operator lock
        pulse(cmd_oper_lock);
        expect_state(CSA_SRC_OPER, 1'b0, 1'b1, 1'b0);
        hold.ext_take <= 1'b1;
        @(negedge clock);
        expect_state(CSA_SRC_OPER, 1'b0, 1'b1, 1'b0);
        ext_beats_lock <= 1'b1;
        @(negedge clock);
        expect_state(CSA_SRC_EXT, 1'b0, 1'b1, 1'b0);
        hold.ext_take <= 1'b0;
        @(negedge clock);
        expect_state(CSA_SRC_OPER, 1'b0, 1'b1, 1'b0);
        pulse(cmd_oper_unlock);
        expect_state(CSA_SRC_OPER, 1'b0, 1'b0, 1'b0);
        // second reset, now powering up into program
        powerup_prog_select <= 1'b1;
        reset <= 1'b1;
        @(negedge clock);
        exp_run = 1'b0;
        expect_state(CSA_SRC_OPER, 1'b0, 1'b0, 1'b0);
        reset <= 1'b0;
        repeat (2) @(negedge clock);
        expect_state(CSA_SRC_PROG, 1'b1, 1'b0, 1'b0);
        @(negedge clock);
        end_of_test();
    end
endmodule
`default_nettype wire

// >>> csa_edge.sv
// csa_edge: rise and fall detection for same-clock command bits
// assumes inputs come from logic on clock; no synchronisation here
`timescale 1ns/1ps
`default_nettype none
module csa_edge
    import csa_pkg::*;
#(
    parameter int unsigned WIDTH = 12
) (
    input  wire logic             clock,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] cmd_in,
    output var  logic [WIDTH-1:0] rise_out,
    output var  logic [WIDTH-1:0] fall_out
);
    logic [WIDTH-1:0] prev_reg;
    logic [WIDTH-1:0] prev_next;

    // previous value, compared with the present one
    always_comb begin
        prev_next = cmd_in;
        rise_out  = cmd_in & ~prev_reg;
        fall_out  = ~cmd_in & prev_reg;
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            prev_reg <= '0;
        end else begin
            prev_reg <= prev_next;
        end
    end
endmodule
`default_nettype wire

// >>> csa_pkg.sv
// csa_pkg: shared types and constants for the command source arbiter
// assumes one scan per clock edge; all command inputs are same-clock logic
package csa_pkg;

    // one-hot ownership codes, highest priority first
    typedef enum logic [5:0] {
        CSA_SRC_HAND  = 6'h20,
        CSA_SRC_MAINT = 6'h10,
        CSA_SRC_OVRD  = 6'h08,
        CSA_SRC_EXT   = 6'h04,
        CSA_SRC_OPER  = 6'h02,
        CSA_SRC_PROG  = 6'h01
    } csa_src_t;

    // ownership flags, same bit order as csa_src_t
    typedef struct packed {
        logic hand;
        logic maint;
        logic ovrd;
        logic ext;
        logic oper;
        logic prog;
    } csa_own_t;

    // every command that can work as a one-shot request
    typedef struct packed {
        logic maint_take;
        logic maint_give;
        logic ext_take;
        logic ext_give;
        logic oper_take;
        logic oper_give;
        logic oper_lock;
        logic oper_unlock;
        logic prog_take;
        logic prog_give;
        logic prog_lock;
        logic prog_unlock;
    } csa_cmd_t;

    // pin inputs that pass the synchroniser
    typedef struct packed {
        logic hand_req;
        logic run_fdbk;
    } csa_pin_t;

    localparam int unsigned CSA_CMD_W      = 12;
    localparam int unsigned CSA_PIN_W      = 2;
    localparam int unsigned CSA_SYNC_DEPTH = 3;

    // reset values
    localparam csa_cmd_t    CSA_CMD_RST    = 12'h000;
    localparam csa_own_t    CSA_OWN_RST    = 6'h00;
    localparam logic [1:0]  CSA_PIN_RST    = 2'h0;
    localparam logic        CSA_BIT_RST    = 1'h0;
    localparam logic        CSA_FIRST_RST  = 1'h1;

endpackage

// >>> csa_src_model.sv
// csa_src_model: operator panel, program and external logic as command sources
// assumes one-scan requests from the bench and clear pulses from the arbiter
`timescale 1ns/1ps
`default_nettype none
module csa_src_model
    import csa_pkg::*;
(
    input  wire logic     clock,
    input  wire logic     reset,
    input  wire csa_cmd_t req,
    input  wire csa_cmd_t hold,
    input  wire csa_cmd_t cmd_clear,
    output var  csa_cmd_t cmd
);
    csa_cmd_t cmd_reg;
    csa_cmd_t cmd_next;
    always_comb begin
        cmd_next = csa_cmd_t'((cmd_reg & ~cmd_clear) | req);
    end
    // changes after the falling edge, away from the scan edge
    always_ff @(negedge clock or posedge reset) begin
        if (reset) begin
            cmd_reg <= CSA_CMD_RST;
        end else begin
            cmd_reg <= cmd_next;
        end
    end
    assign cmd = csa_cmd_t'(cmd_reg | hold);
endmodule
`default_nettype wire

// >>> csa_sync.sv
// csa_sync: three-stage synchroniser for pin inputs, with agreement filter
// assumes inputs are asynchronous to clock; output changes only when
// stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module csa_sync
    import csa_pkg::*;
#(
    parameter int unsigned WIDTH = 2
) (
    input  wire logic             clock,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] pin_in,
    output var  logic [WIDTH-1:0] level_out
);
    logic [WIDTH-1:0] s1_reg, s2_reg, s3_reg, level_reg;
    logic [WIDTH-1:0] level_next;

    // accept a change once the last two stages agree
    always_comb begin
        level_next = level_reg;
        for (int i = 0; i < WIDTH; i++) begin
            if (s2_reg[i] == s3_reg[i]) begin
                level_next[i] = s3_reg[i];
            end
        end
    end

    // first stage feeds only the second
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            s1_reg    <= '0;
            s2_reg    <= '0;
            s3_reg    <= '0;
            level_reg <= '0;
        end else begin
            s1_reg    <= pin_in;
            s2_reg    <= s1_reg;
            s3_reg    <= s2_reg;
            level_reg <= level_next;
        end
    end

    assign level_out = level_reg;
endmodule
`default_nettype wire
